//--- include/cfdc_cfg.svh
`ifndef CFDC_CFG_SVH
`define CFDC_CFG_SVH

// Three-level pin codes
`define CFDC_LVL_LOW        2'h0
`define CFDC_LVL_MID        2'h1
`define CFDC_LVL_HIGH       2'h2
`define CFDC_LVL_FLOAT      2'h3

// Ratio codes: divide by 2**code
`define CFDC_DIV1           2'h0
`define CFDC_DIV2           2'h1
`define CFDC_DIV4           2'h2
`define CFDC_DIV8           2'h3

// Divider counter width (up to /8)
`define CFDC_DIV_W          3

// Clock period in ps
`define CFDC_CLK_PS         4000
// Output turn-off time, ns
`define CFDC_DISABLE_NS     10
// Settling time after enable, us
`define CFDC_SETTLE_US      1
// Largest cycle count for turn-off (round down, at least one)
`define CFDC_DISABLE_CYC    (((`CFDC_DISABLE_NS * 1000) / `CFDC_CLK_PS) < 1 ? 1 : \
                             ((`CFDC_DISABLE_NS * 1000) / `CFDC_CLK_PS))
// Settle count in cycles (round down, longest time)
`define CFDC_SETTLE_CYC     ((`CFDC_SETTLE_US * 1000000) / `CFDC_CLK_PS)
// Settle counter width
`define CFDC_SETTLE_W       10

`endif

//--- include/cfdc_pkg.sv
package cfdc_pkg;

    // Decoded three-level pin value
    typedef logic [1:0] cfdc_level_t;

    // Divide ratio code
    typedef logic [1:0] cfdc_ratio_t;

    // Strap pins as one group
    typedef struct packed {
        cfdc_level_t enable;
        cfdc_level_t ratio_select_high;
        cfdc_level_t ratio_select_low;
    } cfdc_strap_s;

    // Decoded output mode
    typedef struct packed {
        logic        diff_on;
        cfdc_ratio_t diff_ratio;
        logic        se_on;
        cfdc_ratio_t se_ratio;
    } cfdc_mode_s;

    // Top-level sequencing states
    typedef enum logic [1:0] {
        CFDC_OFF    = 2'b00,
        CFDC_SETTLE = 2'b01,
        CFDC_RUN    = 2'b10
    } cfdc_state_e;

endpackage

//--- logic/cfdc_divider.sv
`timescale 1ns/1ps
`include "cfdc_cfg.svh"

// Free-running divider producing /1,/2,/4,/8 taps for one output
module cfdc_divider #(
    parameter int W = `CFDC_DIV_W
) (
    input  wire logic               clk_in,           // Input clock
    input  wire logic               reset_in,         // Sync reset, high
    input  wire logic               clear_in,         // Disabled hold
    input  wire logic               clk_level_in,     // Sampled clock level
    input  wire cfdc_pkg::cfdc_ratio_t ratio_in,      // Ratio code
    output logic                    tap_out           // Selected divided level
);
    import cfdc_pkg::*;

    // Module state in one struct
    typedef struct packed {
        logic [W-1:0] cnt;     // Input clock periods seen
        logic         lvl;     // Previous input clock level
        logic         tap;     // Registered output level
    } cfdc_div_s;

    cfdc_div_s st_ff;      // Registered state
    cfdc_div_s nxt_st;     // Next state

    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lvl = clk_level_in;
        // One count per rising input clock edge, not per system cycle
        if (clk_level_in && !st_ff.lvl) begin
            nxt_st.cnt = st_ff.cnt + W'(1);
        end
        // Undivided tap follows clock state
        if (ratio_in == `CFDC_DIV1) begin
            nxt_st.tap = clk_level_in;
        end else begin
            // Divided tap is counter bit
            nxt_st.tap = nxt_st.cnt[ratio_in - 2'h1];
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tap_out = st_ff.tap;
endmodule // cfdc_divider

//--- logic/cfdc_fanout_ctrl.sv
`timescale 1ns/1ps
`include "cfdc_cfg.svh"
// Contract
// - Each control pin decodes three levels
// - Floating control pin reads as high
// - Straps captured on sampling clock edge
// - Enable low tristates both outputs
// - Enable low resets sequencing, mode and output flops, not the synchronizers
// - Selects ignored while disabled
// - Outputs off soon after enable low
// - Valid clocks about 1us after enable
// - Settling: true high, complement low
// - Then outputs low, then divided clocks
// - Independent divider per output, 1/2/4/8
// - Mode table maps straps to ratios
// - Complement always inverse of true
// - Undivided output takes clock state
// - Stage enable gates drive enable only, both dividers keep running
module cfdc_fanout_ctrl #(
    parameter int SETTLE_CYC = `CFDC_SETTLE_CYC   // Settle length in cycles
) (
    input  wire logic                 clk_in,               // System sampling clock
    input  wire logic                 reset_in,             // Sync reset, high
    input  wire logic                 clk_level_in,         // Input clock level, async
    input  wire cfdc_pkg::cfdc_strap_s strap_in,            // Raw three-level pins, async
    input  wire logic                 diff_stage_en_in,     // Diff driver supply present
    input  wire logic                 se_stage_en_in,       // SE driver supply present
    output logic                      diff_clock_out,       // True diff output
    output logic                      diff_clock_n_out,     // Complement diff output
    output logic                      diff_clock_oe_out,    // Diff drive enable
    output logic                      single_ended_clock_out, // SE output
    output logic                      single_ended_clock_oe_out, // SE drive enable
    output logic                      settling_out          // Settling in progress
);
    import cfdc_pkg::*;

    // All module state
    typedef struct packed {
        cfdc_strap_s   s1;
        cfdc_strap_s   s2;
        cfdc_strap_s   s3;
        cfdc_strap_s   strap;
        logic [2:0]    ck;
        logic          ck_lvl;
        cfdc_state_e   state;
        logic [`CFDC_SETTLE_W-1:0] settle_cnt;
        logic          low_phase;
        cfdc_mode_s    mode;
        logic          diff_q;
        logic          diff_n_q;
        logic          diff_oe;
        logic          se_q;
        logic          se_oe;
        logic          settling;
        logic [1:0]    stg1;       // Stage enable pins, first flop
        logic [1:0]    stg2;       // Stage enable pins, second flop
        logic [1:0]    stg3;       // Stage enable pins, third flop
        logic [1:0]    stage_ok;   // Accepted stage enables, diff then SE
    } cfdc_top_s;

    cfdc_top_s st_ff;      // Registered state
    cfdc_top_s nxt_st;     // Next state
    logic      diff_tap;   // Diff divider tap
    logic      se_tap;     // SE divider tap
    logic      dis_hold;   // Divider hold while disabled
    logic      en_low;     // Captured enable low

    // Mode decode from strap levels
    function automatic cfdc_mode_s decode_mode(input cfdc_strap_s s);
        cfdc_mode_s m;
        cfdc_level_t e;
        cfdc_level_t hi;
        cfdc_level_t lo;
        m = '0;
        e  = (s.enable == `CFDC_LVL_FLOAT) ? `CFDC_LVL_HIGH : s.enable;
        hi = (s.ratio_select_high == `CFDC_LVL_FLOAT) ? `CFDC_LVL_HIGH : s.ratio_select_high;
        lo = (s.ratio_select_low == `CFDC_LVL_FLOAT) ? `CFDC_LVL_HIGH : s.ratio_select_low;
        unique case ({e, hi, lo})
            {`CFDC_LVL_MID, `CFDC_LVL_LOW, `CFDC_LVL_MID}: begin
                m = '{1'b1, `CFDC_DIV1, 1'b1, `CFDC_DIV1};
            end
            {`CFDC_LVL_MID, `CFDC_LVL_MID, `CFDC_LVL_HIGH}: begin
                m = '{1'b1, `CFDC_DIV1, 1'b1, `CFDC_DIV2};
            end
            {`CFDC_LVL_HIGH, `CFDC_LVL_LOW, `CFDC_LVL_LOW}: begin
                m = '{1'b1, `CFDC_DIV1, 1'b1, `CFDC_DIV4};
            end
            {`CFDC_LVL_MID, `CFDC_LVL_LOW, `CFDC_LVL_HIGH}: begin
                m = '{1'b1, `CFDC_DIV2, 1'b1, `CFDC_DIV2};
            end
            {`CFDC_LVL_HIGH, `CFDC_LVL_LOW, `CFDC_LVL_HIGH}: begin
                m = '{1'b1, `CFDC_DIV2, 1'b1, `CFDC_DIV4};
            end
            {`CFDC_LVL_MID, `CFDC_LVL_LOW, `CFDC_LVL_LOW}: begin
                m = '{1'b1, `CFDC_DIV4, 1'b1, `CFDC_DIV4};
            end
            {`CFDC_LVL_MID, `CFDC_LVL_HIGH, `CFDC_LVL_LOW}: begin
                m = '{1'b1, `CFDC_DIV4, 1'b1, `CFDC_DIV8};
            end
            {`CFDC_LVL_MID, `CFDC_LVL_MID, `CFDC_LVL_MID}: begin
                m = '{1'b1, `CFDC_DIV8, 1'b1, `CFDC_DIV1};
            end
            {`CFDC_LVL_HIGH, `CFDC_LVL_HIGH, `CFDC_LVL_LOW}: begin
                m = '{1'b1, `CFDC_DIV8, 1'b1, `CFDC_DIV4};
            end
            {`CFDC_LVL_HIGH, `CFDC_LVL_HIGH, `CFDC_LVL_HIGH}: begin
                m = '{1'b0, `CFDC_DIV1, 1'b1, `CFDC_DIV4};
            end
            default: begin
                m = '0;
            end
        endcase
        return m;
    endfunction

    // Enable low is the low level only
    assign en_low = (st_ff.strap.enable == `CFDC_LVL_LOW);
    assign dis_hold = (st_ff.state != CFDC_RUN) || st_ff.low_phase;

    // Diff divider
    cfdc_divider #(.W(`CFDC_DIV_W)) u_diff_div (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .clear_in     (dis_hold),
        .clk_level_in (st_ff.ck_lvl),
        .ratio_in     (st_ff.mode.diff_ratio),
        .tap_out      (diff_tap)
    );

    // SE divider
    cfdc_divider #(.W(`CFDC_DIV_W)) u_se_div (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .clear_in     (dis_hold),
        .clk_level_in (st_ff.ck_lvl),
        .ratio_in     (st_ff.mode.se_ratio),
        .tap_out      (se_tap)
    );

    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = strap_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.ck = {st_ff.ck[1:0], clk_level_in};
        // Accept once stages two and three agree
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.strap = st_ff.s3;
        end
        if (st_ff.ck[1] == st_ff.ck[2]) begin
            nxt_st.ck_lvl = st_ff.ck[2];
        end
        // Stage supply pins pass three flops, bit 1 diff, bit 0 SE
        nxt_st.stg1 = {diff_stage_en_in, se_stage_en_in};
        nxt_st.stg2 = st_ff.stg1;
        nxt_st.stg3 = st_ff.stg2;
        if (st_ff.stg2 == st_ff.stg3) begin
            nxt_st.stage_ok = st_ff.stg3;
        end
        unique case (st_ff.state)
            CFDC_OFF: begin
                if (!en_low) begin
                    nxt_st.state = CFDC_SETTLE;
                    nxt_st.settle_cnt = '0;
                end
            end
            CFDC_SETTLE: begin
                if (st_ff.settle_cnt >= `CFDC_SETTLE_W'(SETTLE_CYC - 1)) begin
                    nxt_st.state = CFDC_RUN;
                    nxt_st.low_phase = 1'b1;
                    nxt_st.mode = decode_mode(st_ff.strap);
                end else begin
                    nxt_st.settle_cnt = st_ff.settle_cnt + `CFDC_SETTLE_W'(1);
                end
            end
            CFDC_RUN: begin
                // One low cycle, then divided clocks
                nxt_st.low_phase = 1'b0;
                nxt_st.mode = decode_mode(st_ff.strap);
            end
            default: begin
                nxt_st.state = CFDC_OFF;
            end
        endcase
        // Output drive follows the state being entered, so it lines up with settling
        nxt_st.settling = (nxt_st.state == CFDC_SETTLE);
        if (nxt_st.state == CFDC_SETTLE) begin
            nxt_st.diff_q   = 1'b1;
            nxt_st.diff_n_q = 1'b0;
            nxt_st.diff_oe  = 1'b1;
            nxt_st.se_q     = 1'b0;
            nxt_st.se_oe    = 1'b1;
        end else if (nxt_st.state == CFDC_RUN) begin
            nxt_st.diff_q   = nxt_st.low_phase ? 1'b0 : diff_tap;
            nxt_st.diff_n_q = nxt_st.low_phase ? 1'b1 : ~diff_tap;
            nxt_st.diff_oe  = nxt_st.mode.diff_on & st_ff.stage_ok[1];
            nxt_st.se_q     = nxt_st.low_phase ? 1'b0 : se_tap;
            nxt_st.se_oe    = nxt_st.mode.se_on & st_ff.stage_ok[0];
        end else begin
            nxt_st.diff_q   = 1'b0;
            nxt_st.diff_n_q = 1'b1;
            nxt_st.diff_oe  = 1'b0;
            nxt_st.se_q     = 1'b0;
            nxt_st.se_oe    = 1'b0;
        end
        if (en_low) begin
            nxt_st.state      = CFDC_OFF;
            nxt_st.settle_cnt = '0;
            nxt_st.low_phase  = 1'b0;
            nxt_st.mode       = '0;
            nxt_st.diff_q     = 1'b0;
            nxt_st.diff_n_q   = 1'b1;
            nxt_st.diff_oe    = 1'b0;
            nxt_st.se_q       = 1'b0;
            nxt_st.se_oe      = 1'b0;
            nxt_st.settling   = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_ff <= '{default: '0, diff_n_q: 1'b1, state: CFDC_OFF};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs from flip-flops
    assign diff_clock_out            = st_ff.diff_q;
    assign diff_clock_n_out          = st_ff.diff_n_q;
    assign diff_clock_oe_out         = st_ff.diff_oe;
    assign single_ended_clock_out    = st_ff.se_q;
    assign single_ended_clock_oe_out = st_ff.se_oe;
    assign settling_out              = st_ff.settling;
endmodule // cfdc_fanout_ctrl

//--- dv/cfdc_fanout_ctrl_props.sv
`timescale 1ns/1ps
`include "cfdc_cfg.svh"
// Port watcher for the fanout control block
module cfdc_fanout_ctrl_props #(
    parameter int SETTLE_CYC = `CFDC_SETTLE_CYC       // Settle length in cycles
) (
    input wire logic                  clk_in,
    input wire logic                  reset_in,
    input wire logic                  clk_level_in,
    input wire cfdc_pkg::cfdc_strap_s strap_in,
    input wire logic                  diff_stage_en_in,
    input wire logic                  se_stage_en_in,
    input wire logic                  diff_clock_out,
    input wire logic                  diff_clock_n_out,
    input wire logic                  diff_clock_oe_out,
    input wire logic                  single_ended_clock_out,
    input wire logic                  single_ended_clock_oe_out,
    input wire logic                  settling_out
);
    import cfdc_pkg::*;
    logic [15:0] settle_cnt_ff;                       // Cycles spent settling
    logic        en_low;                              // Enable pin at low level
    logic        top_mode;                            // All pins high or floating
    assign en_low = strap_in.enable == `CFDC_LVL_LOW;
    assign top_mode = strap_in >= 6'h2a && strap_in[3:2] >= 2'h2 && strap_in[1:0] >= 2'h2;
    // Count settle length
    always_ff @(posedge clk_in) begin
        settle_cnt_ff <= settling_out ? settle_cnt_ff + 16'h1 : 16'h0;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_reset_state: assert property ($fell(reset_in) |-> !diff_clock_oe_out
        && !single_ended_clock_oe_out && diff_clock_n_out && !settling_out) else $error("bad reset");
    a_comp_inverse: assert property (!settling_out && diff_clock_oe_out
        |-> diff_clock_n_out == !diff_clock_out) else $error("complement wrong");
    a_settle_level: assert property (settling_out |-> diff_clock_out
        && !diff_clock_n_out && diff_clock_oe_out) else $error("settle levels wrong");
    a_settle_len: assert property ($fell(settling_out)
        |-> settle_cnt_ff == SETTLE_CYC) else $error("settle length wrong");
    a_settle_exit: assert property ($fell(settling_out)
        |-> !diff_clock_out && !single_ended_clock_out) else $error("exit not low");
    a_disable_off: assert property (en_low[*6] |=> !diff_clock_oe_out
        && !single_ended_clock_oe_out && !settling_out) else $error("not disabled");
    a_mode_off: assert property (top_mode[*6] ##0 !settling_out
        |=> !diff_clock_oe_out) else $error("diff not off");
    a_stage_gate: assert property (!se_stage_en_in[*5]
        |=> !single_ended_clock_oe_out) else $error("stage gate");
    c_settle: cover property ($rose(settling_out));
    c_run: cover property ($fell(settling_out));
    c_se_on: cover property ($rose(single_ended_clock_oe_out));
endmodule // cfdc_fanout_ctrl_props

bind cfdc_fanout_ctrl cfdc_fanout_ctrl_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (.clk_in,
    .reset_in, .clk_level_in, .strap_in, .diff_stage_en_in, .se_stage_en_in, .diff_clock_out,
    .diff_clock_n_out, .diff_clock_oe_out, .single_ended_clock_out,
    .single_ended_clock_oe_out, .settling_out);

//--- dv/cfdc_strap_board.sv
`timescale 1ns/1ps
// Board straps and input clock as seen by the control block
module cfdc_strap_board (
    input  wire logic                  clk_in,        // Sampling clock
    input  wire cfdc_pkg::cfdc_strap_s want_in,       // Requested pin levels
    output cfdc_pkg::cfdc_strap_s      strap_out,     // Levels on the pins
    output logic                       clk_level_out  // Input clock level
);
    import cfdc_pkg::*;
    logic [1:0] ph_ff;                                // Input clock half-period count
    initial strap_out = 6'h20;
    initial clk_level_out = 1'b0;
    initial ph_ff = 2'h0;
    // three-level pins moved only away from the sampling edge
    always @(negedge clk_in) begin
        strap_out <= want_in;
        ph_ff <= ph_ff + 2'h1;
        // Input clock is slow enough for the two-flop agreement filter
        if (ph_ff == 2'h3) begin
            clk_level_out <= ~clk_level_out;
        end
    end
endmodule // cfdc_strap_board

//--- dv/test_cfdc_fanout_ctrl.sv
`timescale 1ns/1ps
// Self-checking bench for the fanout control block
module test_cfdc_fanout_ctrl;
    import cfdc_pkg::*;
    localparam int SC = 4;                      // Shortened settle
    logic        clk_in, reset_in, dse, sse;    // Clock, reset, stage enables
    logic        lvl, d, dn, doe, se, seoe, st; // Clock level and outputs
    cfdc_strap_s want, strap;                   // Requested and applied pins
    int          error_cnt, num_checks, cyc;    // Counters
    int          td, ts, base;                  // Toggle counts
    // Mode table: pins, diff code, se code, diff off
    logic [10:0] mt [12] = '{{6'h11,4'h0,1'b0}, {6'h16,4'h1,1'b0}, {6'h20,4'h2,1'b0},
        {6'h12,4'h5,1'b0}, {6'h22,4'h6,1'b0}, {6'h10,4'ha,1'b0}, {6'h18,4'hb,1'b0},
        {6'h15,4'hc,1'b0}, {6'h28,4'he,1'b0}, {6'h2a,4'h2,1'b1}, {6'h3f,4'h2,1'b1},
        {6'h30,4'h2,1'b0}};
    cfdc_strap_board u_board (.clk_in(clk_in), .want_in(want), .strap_out(strap),
        .clk_level_out(lvl));
    cfdc_fanout_ctrl #(.SETTLE_CYC(SC)) dut (.clk_in(clk_in), .reset_in(reset_in),
        .clk_level_in(lvl), .strap_in(strap), .diff_stage_en_in(dse), .se_stage_en_in(sse),
        .diff_clock_out(d), .diff_clock_n_out(dn), .diff_clock_oe_out(doe),
        .single_ended_clock_out(se), .single_ended_clock_oe_out(seoe), .settling_out(st));
    // Clock generator
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s exp %0h seen %0h", name, exp, seen);
            error_cnt++;
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic pins(logic [5:0] p, int n);
        @(negedge clk_in);
        want = p;
        repeat (n) @(negedge clk_in);
    endtask
    // Count output toggles over 256 cycles
    task automatic count();
        logic pd, ps;
        td = 0;
        ts = 0;
        for (int i = 0; i < 256; i++) begin
            pd = d;
            ps = se;
            @(negedge clk_in);
            td += (d !== pd);
            ts += (se !== ps);
        end
    endtask
    task automatic settle_done();
        int n;
        n = 0;
        for (int i = 0; i < 20 && !st; i++) @(negedge clk_in);
        chk("settle_d", {d, dn, doe}, 3'b101);
        while (st === 1'b1 && n < 20) begin
            n++;
            @(negedge clk_in);
        end
        chk("settle_len", n, SC);
        chk("exit_low", {d, se}, 2'b00);
    endtask
    task automatic t_modes();
        int rd, rs;
        for (int i = 0; i < 12; i++) begin
            pins(mt[i][10:5], 10);
            count();
            rd = 1 << mt[i][4:3];
            rs = 1 << mt[i][2:1];
            chk("oe", {doe, seoe}, {~mt[i][0], 1'b1});
            chk("se_ratio", ts * rs >= base - 2 * rs && ts * rs <= base + 2 * rs, 1);
            if (!mt[i][0]) chk("d_ratio", td * rd >= base - 2 * rd && td * rd <= base + 2 * rd, 1);
        end
    endtask
    task automatic t_disable();
        pins(6'h1a, 10);
        chk("unlisted", {doe, seoe}, 2'b00);
        pins(6'h0a, 6);
        chk("off", {doe, seoe, st}, 3'b000);
        pins(6'h05, 20);
        chk("sel_ignored", {doe, seoe, st, d}, 4'h0);
        pins(6'h11, 0);
        settle_done();
    endtask
    task automatic t_stage();
        pins(6'h11, 8);
        sse = 1'b0;
        repeat (6) @(negedge clk_in);
        chk("se_gated", {doe, seoe}, 2'b10);
        sse = 1'b1;
        repeat (3) @(negedge clk_in);
        count();
        chk("se_back", seoe, 1'b1);
        chk("se_follow", ts >= base - 2 && ts <= base + 2, 1);
    endtask
    task automatic t_reset();
        reset_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk("reset", {doe, seoe, dn, st}, 4'h2);
        reset_in = 1'b0;
        settle_done();
    endtask
    // Main sequence
    initial begin
        reset_in = 1'b1;
        dse = 1'b1;
        sse = 1'b1;
        want = 6'h00;
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        repeat (6) @(negedge clk_in);
        reset_in = 1'b0;
        pins(6'h00, 8);
        pins(6'h11, 0);
        settle_done();
        repeat (8) @(negedge clk_in);
        count();
        base = td;
        chk("base", td >= 63 && td <= 65, 1);
        t_modes();
        t_disable();
        t_stage();
        t_reset();
        give_verdict();
    end
endmodule // test_cfdc_fanout_ctrl
